// file: rtl/multimode_timer.sv
// multimode 16-bit timer: waveform, external event count and input
// capture, with two reload/capture registers, reached over apb
// assumes: pclk is the fast internal clock, the instruction clock is
// derived from it; timer pins are asynchronous; power_save_freeze
// comes from the clock controller on pclk
//
// Functional notes
// - 16-bit down-counter, two reload/capture registers
// - speed bit picks fast or instruction clock
// - event mode counts synchronised pin A edges
// - mode 000 rising, 001 falling edges
// - event underflow sets pending A, irq if enabled
// - pin B rising sets pending B there
// - no waveform drive on pin A there
// - capture counter runs freely, reads harmless
// - pin edges copy counter into A/B
// - capture edge per pin from mode bits
// - capture edges set pending flags, gated irq
// - capture underflow sets run flag, irq A
// - run flag starts/stops wave and event
// - enables gate irqs; pending flags latch
// - wave modes reload alternately, optional pin toggle
// - control register writable anytime safely
// - power save freezes hardware-driven state; apb writes still land
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "timer_defines.svh"

module multimode_timer #(
    parameter int INST_DIV = `TMR_INST_DIV
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // timer pin a: two-way
    input  wire logic        timer_pin_a_in,
    output logic             timer_pin_a_out,
    output logic             timer_pin_a_oe,
    // timer pin b: input only
    input  wire logic        timer_pin_b_in,
    // power save
    input  wire logic        power_save_freeze,
    // interrupt requests
    output logic             irq_a,
    output logic             irq_b
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pin_event_if ev_a ();
    pin_event_if ev_b ();

    pin_sync u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (timer_pin_a_in),
        .ev      (ev_a)
    );

    pin_sync u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (timer_pin_b_in),
        .ev      (ev_b)
    );

    // ------------------------------------------------------------------
    // state and next state
    // ------------------------------------------------------------------
    timer_pkg::timer_state_t q;
    timer_pkg::timer_state_t d;

    localparam logic [7:0] DIV_LAST = 8'(INST_DIV - 1);

    timer_pkg::mode_kind_t kind;
    logic                  tick;
    logic                  access;
    logic                  wr_done;
    logic                  count_edge;
    logic                  cap_edge_a;
    logic                  cap_edge_b;
    logic                  set_pend_a;
    logic                  set_pend_b;
    logic                  set_underflow;
    logic                  addr_ok;
    logic [31:0]           rd_word;

    // mode decode: bit1 set means capture, else bit2 set means waveform
    always_comb begin
        if (q.mode[1]) begin
            kind = timer_pkg::MODE_CAPTURE;
        end else if (q.mode[2]) begin
            kind = timer_pkg::MODE_WAVE;
        end else begin
            kind = timer_pkg::MODE_EVENT;
        end
    end

    // active counting rate: every pclk when fast, else the divider
    assign tick = q.fast | (q.div == DIV_LAST);

    // edge choice per pin
    assign count_edge = q.mode[0] ? ev_a.fall : ev_a.rise;
    assign cap_edge_a = q.mode[0] ? ev_a.fall : ev_a.rise;
    assign cap_edge_b = q.mode[2] ? ev_b.fall : ev_b.rise;

    // apb handshake: one wait state so every output is a flop
    assign access  = psel & penable;
    assign wr_done = access & q.pready & pwrite & ~q.pslverr;

    // read mux and address check
    always_comb begin
        rd_word = `TMR_RST_DATA;
        addr_ok = 1'b1;
        unique case (paddr)
            `TMR_OFS_CTRL: begin
                rd_word[`TMR_CTRL_RUN]                    = q.run_flag;
                rd_word[`TMR_CTRL_MODE2:`TMR_CTRL_MODE0]  = q.mode;
                rd_word[`TMR_CTRL_EN_B]                   = q.en_b;
                rd_word[`TMR_CTRL_PEND_B]                 = q.pend_b;
                rd_word[`TMR_CTRL_EN_A]                   = q.en_a;
                rd_word[`TMR_CTRL_PEND_A]                 = q.pend_a;
            end
            `TMR_OFS_FAST: begin
                rd_word[`TMR_FAST_SEL] = q.fast;
            end
            `TMR_OFS_COUNT: begin
                rd_word[15:0] = q.count;
            end
            `TMR_OFS_RELOAD_A: begin
                rd_word[15:0] = q.rel_a;
            end
            `TMR_OFS_RELOAD_B: begin
                rd_word[15:0] = q.rel_b;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d             = q;
        set_pend_a    = 1'b0;
        set_pend_b    = 1'b0;
        set_underflow = 1'b0;

        // hardware side; the freeze skips it, so only apb writes and answers move state
        if (!power_save_freeze) begin
            d.div = tick ? `TMR_RST_DIV : q.div + 8'h01;

            unique case (kind)
                timer_pkg::MODE_WAVE: begin
                    if (!q.run_flag) begin
                        // first underflow after a start reloads from a
                        d.next_b = 1'b0;
                    end else if (tick) begin
                        if (q.count == `TMR_RST_WORD16) begin
                            // alternate reloads, flag the source
                            d.count  = q.next_b ? q.rel_b : q.rel_a;
                            d.next_b = ~q.next_b;
                            set_pend_a = ~q.next_b;
                            set_pend_b = q.next_b;
                            if (q.mode[0]) begin
                                d.pin_lvl = ~q.pin_lvl;
                            end
                        end else begin
                            d.count = q.count - 16'h0001;
                        end
                    end
                end
                timer_pkg::MODE_EVENT: begin
                    // an edge seen between slow ticks waits for the tick
                    if (q.run_flag && count_edge) begin
                        d.edge_hold = 1'b1;
                    end
                    if (q.run_flag && tick && (q.edge_hold || count_edge)) begin
                        d.edge_hold = 1'b0;
                        if (q.count == `TMR_RST_WORD16) begin
                            d.count    = q.rel_a;
                            set_pend_a = 1'b1;
                        end else begin
                            d.count = q.count - 16'h0001;
                        end
                    end
                    if (!q.run_flag) begin
                        d.edge_hold = 1'b0;
                    end
                    // pin b is an independent rising-edge input
                    set_pend_b = ev_b.rise;
                end
                timer_pkg::MODE_CAPTURE: begin
                    d.edge_hold = 1'b0;
                    // free running: the run flag does not stop it here
                    if (tick) begin
                        d.count = q.count - 16'h0001;
                        set_underflow = (q.count == `TMR_RST_WORD16);
                    end
                    if (cap_edge_a) begin
                        d.rel_a    = q.count;
                        set_pend_a = 1'b1;
                    end
                    if (cap_edge_b) begin
                        d.rel_b    = q.count;
                        set_pend_b = 1'b1;
                    end
                end
            endcase
        end

        // hardware sets first; software writes may not drop them
        d.pend_a   = q.pend_a | set_pend_a;
        d.pend_b   = q.pend_b | set_pend_b;
        d.run_flag = q.run_flag | set_underflow;

        // software side
        if (wr_done) begin
            unique case (paddr)
                `TMR_OFS_CTRL: begin
                    // any write is safe at any time; fresh events win
                    d.mode     = pwdata[`TMR_CTRL_MODE2:`TMR_CTRL_MODE0];
                    d.en_a     = pwdata[`TMR_CTRL_EN_A];
                    d.en_b     = pwdata[`TMR_CTRL_EN_B];
                    d.pend_a   = pwdata[`TMR_CTRL_PEND_A] | set_pend_a;
                    d.pend_b   = pwdata[`TMR_CTRL_PEND_B] | set_pend_b;
                    d.run_flag = pwdata[`TMR_CTRL_RUN] | set_underflow;
                end
                `TMR_OFS_FAST: begin
                    d.fast = pwdata[`TMR_FAST_SEL];
                end
                `TMR_OFS_COUNT: begin
                    // a running fast timer may race this write
                    d.count = pwdata[15:0];
                end
                `TMR_OFS_RELOAD_A: begin
                    if (!(kind == timer_pkg::MODE_CAPTURE && cap_edge_a)) begin
                        d.rel_a = pwdata[15:0];
                    end
                end
                `TMR_OFS_RELOAD_B: begin
                    if (!(kind == timer_pkg::MODE_CAPTURE && cap_edge_b)) begin
                        d.rel_b = pwdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // pin a drives only in waveform modes
        d.pin_oe = d.mode[2] & ~d.mode[1];

        // interrupt requests; a shares capture and underflow
        d.irq_a = d.en_a & (d.pend_a | (d.mode[1] & d.run_flag));
        d.irq_b = d.en_b & d.pend_b;

        // apb answer, registered one cycle into the access phase
        d.pready = access & ~q.pready;
        if (access && !q.pready) begin
            d.prdata  = addr_ok ? rd_word : `TMR_RST_DATA;
            d.pslverr = ~addr_ok;
        end else if (!access) begin
            d.pslverr = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.mode  <= `TMR_RST_MODE;
            q.count <= `TMR_RST_WORD16;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign pready          = q.pready;
    assign prdata          = q.prdata;
    assign pslverr         = q.pslverr;
    assign timer_pin_a_out = q.pin_lvl;
    assign timer_pin_a_oe  = q.pin_oe;
    assign irq_a           = q.irq_a;
    assign irq_b           = q.irq_b;

endmodule : multimode_timer

// file: rtl/timer_defines.svh
// constants of the multimode timer: register offsets, field positions,
// reset values and timing counts
// assumes: included by bare name from every file that needs a number
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------
`define TMR_OFS_CTRL      12'h000
`define TMR_OFS_FAST      12'h004
`define TMR_OFS_COUNT     12'h008
`define TMR_OFS_RELOAD_A  12'h00C
`define TMR_OFS_RELOAD_B  12'h010

// ----------------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------------
`define TMR_CTRL_RUN      0
`define TMR_CTRL_MODE0    1
`define TMR_CTRL_MODE2    3
`define TMR_CTRL_EN_B     4
`define TMR_CTRL_PEND_B   5
`define TMR_CTRL_EN_A     6
`define TMR_CTRL_PEND_A   7
`define TMR_FAST_SEL      0

// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define TMR_RST_WORD16    16'h0000
`define TMR_RST_MODE      3'h0
`define TMR_RST_DIV       8'h00
`define TMR_RST_DATA      32'h0000_0000
// fast clock cycles per instruction cycle
`define TMR_INST_DIV      10

`endif

// file: rtl/timer_pkg.sv
// types of the multimode timer: state records of both modules and
// the decoded mode kinds
// assumes: timer_defines.svh supplies the numbers
package timer_pkg;

    // ------------------------------------------------------------------
    // decoded operating mode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_WAVE,
        MODE_EVENT,
        MODE_CAPTURE
    } mode_kind_t;

    // ------------------------------------------------------------------
    // pin synchroniser state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } pin_sync_state_t;

    // ------------------------------------------------------------------
    // timer block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] rel_a;
        logic [15:0] rel_b;
        logic [2:0]  mode;
        logic        run_flag;
        logic        pend_a;
        logic        pend_b;
        logic        en_a;
        logic        en_b;
        logic        fast;
        logic [7:0]  div;
        logic        next_b;
        logic        edge_hold;
        logic        pin_lvl;
        logic        pin_oe;
        logic        irq_a;
        logic        irq_b;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } timer_state_t;

endpackage : timer_pkg

// file: rtl/pin_event_if.sv
// carrier between a pin synchroniser and the timer core
// assumes: one synchroniser drives it, the core only reads it
`timescale 1ns/1ns

interface pin_event_if;
    logic level;
    logic rise;
    logic fall;

    modport source (output level, output rise, output fall);
    modport sink   (input level, input rise, input fall);
endinterface : pin_event_if

// file: rtl/pin_sync.sv
// two-flop synchroniser with edge detect for one timer pin
// assumes: pin is asynchronous to pclk; reset is asynchronous low
`timescale 1ns/1ns

module pin_sync (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // raw pin
    input  wire logic   pin_in,
    // synchronised level and edge pulses
    pin_event_if.source ev
);

    timer_pkg::pin_sync_state_t q;
    timer_pkg::pin_sync_state_t d;

    // meta is only ever read by sync; edges come from sync and prev
    always_comb begin
        d      = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // one pulse per physical edge
    assign ev.level = q.sync;
    assign ev.rise  = q.sync & ~q.prev;
    assign ev.fall  = ~q.sync & q.prev;

endmodule : pin_sync

// file: tb/multimode_timer_sva.sv
// checker for the multimode timer, watching its top-level ports only
// assumes: bound into multimode_timer; control writes seen on apb
`timescale 1ns/1ns

module timer_sva #(
    parameter int INST_DIV = 10
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // pins
    input wire logic        timer_pin_a_in,
    input wire logic        timer_pin_a_out,
    input wire logic        timer_pin_a_oe,
    input wire logic        timer_pin_b_in,
    input wire logic        power_save_freeze,
    // interrupts
    input wire logic        irq_a,
    input wire logic        irq_b
);
    // ------------------------------------------------------------------
    // shadow of the written mode and enables
    // ------------------------------------------------------------------
    logic       ctrl_wr;
    logic [2:0] mode_q;
    logic       en_a_q;
    logic       en_b_q;

    assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 12'h000);

    // only software writes move these, so hardware flags need no model
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 3'h0;
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
        end else if (ctrl_wr) begin
            mode_q <= pwdata[3:1];
            en_a_q <= pwdata[6];
            en_b_q <= pwdata[4];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait;   psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready;         endsequence
    sequence s_frozen; (power_save_freeze && !psel) [*3]; endsequence

    property p_answer;   s_wait |=> s_answer; endproperty
    property p_unmapped; pready && (paddr > 12'h010) |-> pslverr && (prdata == 32'h0); endproperty
    property p_oe_off;   ctrl_wr && (pwdata[3:2] != 2'b10) |-> ##2 !timer_pin_a_oe; endproperty
    property p_oe_on;    ctrl_wr && (pwdata[3:2] == 2'b10) |-> ##2 timer_pin_a_oe; endproperty
    property p_toggle;
        !$stable(timer_pin_a_out) |-> (mode_q == 3'h5) || ($past(mode_q) == 3'h5);
    endproperty
    property p_irq_b_gate; $rose(irq_b) |-> en_b_q; endproperty
    property p_irq_a_off;  ctrl_wr && !pwdata[6] |-> ##2 !irq_a; endproperty
    property p_pin_b;
        en_b_q && !mode_q[2] && !power_save_freeze && $rose(timer_pin_b_in) |-> ##[2:8] irq_b;
    endproperty
    property p_cap_a;
        en_a_q && mode_q[1] && !mode_q[0] && !power_save_freeze && $rose(timer_pin_a_in)
            |-> ##[2:8] irq_a;
    endproperty
    property p_freeze;
        s_frozen |-> $stable(irq_a) && $stable(irq_b) && $stable(timer_pin_a_out);
    endproperty

    a_answer:     assert property (p_answer)     else $error("apb answer timing wrong");
    a_unmapped:   assert property (p_unmapped)   else $error("unmapped not refused");
    a_oe_off:     assert property (p_oe_off)     else $error("pin a driven off wave");
    a_oe_on:      assert property (p_oe_on)      else $error("pin a not driven");
    a_toggle:     assert property (p_toggle)     else $error("pin a toggled wrongly");
    a_irq_b_gate: assert property (p_irq_b_gate) else $error("irq b while disabled");
    a_irq_a_off:  assert property (p_irq_a_off)  else $error("irq a not masked");
    a_pin_b:      assert property (p_pin_b)      else $error("pin b edge lost");
    a_cap_a:      assert property (p_cap_a)      else $error("capture a irq lost");
    a_freeze:     assert property (p_freeze)     else $error("state moved in freeze");
endmodule : timer_sva

bind multimode_timer timer_sva #(.INST_DIV(INST_DIV)) sva_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_pin_a_in(timer_pin_a_in), .timer_pin_a_out(timer_pin_a_out),
    .timer_pin_a_oe(timer_pin_a_oe), .timer_pin_b_in(timer_pin_b_in),
    .power_save_freeze(power_save_freeze), .irq_a(irq_a), .irq_b(irq_b)
);

// file: tb/pin_source.sv
// external signal sources on the two timer pins
// assumes: the bench calls drive(); levels change just after a clock edge
`timescale 1ns/1ns

module pin_source (
    // clock
    input  wire logic clk,
    // pin levels
    output logic      pin_a,
    output logic      pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // hold time n lets a caller pace the edges
    task automatic drive(input logic a, input logic b, input int n);
        @(posedge clk);
        pin_a <= a;
        pin_b <= b;
        repeat (n) @(posedge clk);
    endtask : drive
endmodule : pin_source

// file: tb/tb_multimode_timer.sv
// self-checking bench for the multimode timer
// assumes: pin_source drives the pins; apb master tasks below
`timescale 1ns/1ns
`include "timer_defines.svh"

module tb_multimode_timer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, freeze;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pin_out, pin_oe, src_a, pin_b, pin_a, irq_a, irq_b, last_err;
    int          errors, check_count;

    // pin a wire: the design wins while it drives
    assign pin_a = pin_oe ? pin_out : src_a;

    pin_source pins (.clk(pclk), .pin_a(src_a), .pin_b(pin_b));

    multimode_timer #(.INST_DIV(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .timer_pin_a_in(pin_a), .timer_pin_a_out(pin_out), .timer_pin_a_oe(pin_oe),
        .timer_pin_b_in(pin_b), .power_save_freeze(freeze), .irq_a(irq_a), .irq_b(irq_b)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    // one apb transfer; waits up to 50 cycles for pready, then flags no answer
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        r        = prdata;
        last_err = pslverr;
        chk(n < 50, "apb no answer");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string msg);
        logic [31:0] r;
        rd(a, r);
        chk(r === e && last_err === 1'b0, msg);
    endtask : rd_chk

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        rd_chk(`TMR_OFS_CTRL, 32'h0, "ctrl reset");
        rd_chk(`TMR_OFS_FAST, 32'h0, "fast reset");
        rd(12'h020, r);
        chk(r === 32'h0 && last_err === 1'b1, "unmapped read");
    endtask : t_reset

    task automatic t_event;
        wr(`TMR_OFS_RELOAD_A, 32'h3);
        wr(`TMR_OFS_COUNT, 32'h2);
        wr(`TMR_OFS_CTRL, 32'h41);
        repeat (2) begin
            pins.drive(1'b1, 1'b0, 6);
            pins.drive(1'b0, 1'b0, 6);
        end
        rd_chk(`TMR_OFS_COUNT, 32'h0, "rising edges counted");
        pins.drive(1'b1, 1'b0, 8);
        rd_chk(`TMR_OFS_COUNT, 32'h3, "reload after underflow");
        rd_chk(`TMR_OFS_CTRL, 32'hC1, "pending a on underflow");
        chk(irq_a === 1'b1, "irq a on underflow");
        wr(`TMR_OFS_CTRL, 32'h03);
        pins.drive(1'b0, 1'b0, 8);
        rd_chk(`TMR_OFS_COUNT, 32'h2, "falling edge counted");
        pins.drive(1'b1, 1'b0, 8);
        rd_chk(`TMR_OFS_COUNT, 32'h2, "rising edge ignored");
        pins.drive(1'b0, 1'b0, 8);
        chk(irq_a === 1'b0, "irq a masked");
    endtask : t_event

    task automatic t_pin_b;
        wr(`TMR_OFS_CTRL, 32'h10);
        pins.drive(1'b0, 1'b1, 8);
        rd_chk(`TMR_OFS_CTRL, 32'h30, "pending b while stopped");
        chk(irq_b === 1'b1, "irq b raised");
        wr(`TMR_OFS_CTRL, 32'h10);
        pins.drive(1'b0, 1'b0, 3);
        chk(irq_b === 1'b0, "irq b cleared");
    endtask : t_pin_b

    task automatic t_capture;
        logic [31:0] c1, c2, cap;
        wr(`TMR_OFS_COUNT, 32'h8000);
        wr(`TMR_OFS_CTRL, 32'h54);
        rd(`TMR_OFS_COUNT, c1);
        pins.drive(1'b1, 1'b0, 8);
        rd(`TMR_OFS_COUNT, c2);
        rd(`TMR_OFS_RELOAD_A, cap);
        chk(c2 < c1 && cap <= c1 && cap >= c2, "capture of running count");
        pins.drive(1'b0, 1'b0, 8);
    endtask : t_capture

    // each capture mode: which pin edges set the pending flags
    task automatic t_cap_modes;
        logic [2:0]  modes [4];
        logic [2:0]  m;
        logic [31:0] base;
        modes = '{3'b010, 3'b110, 3'b011, 3'b111};
        for (int i = 0; i < 4; i++) begin
            m    = modes[i];
            base = 32'h50 | {28'h0, m, 1'b0};
            wr(`TMR_OFS_CTRL, base);
            pins.drive(1'b1, 1'b1, 8);
            rd_chk(`TMR_OFS_CTRL, base | {24'h0, ~m[0], 1'b0, ~m[2], 5'h0}, "rise");
            chk(irq_b === ~m[2], "irq b on rise");
            wr(`TMR_OFS_CTRL, base);
            pins.drive(1'b0, 1'b0, 8);
            rd_chk(`TMR_OFS_CTRL, base | {24'h0, m[0], 1'b0, m[2], 5'h0}, "fall");
        end
    endtask : t_cap_modes

    task automatic t_underflow;
        wr(`TMR_OFS_FAST, 32'h1);
        wr(`TMR_OFS_CTRL, 32'h44);
        wr(`TMR_OFS_COUNT, 32'h3);
        repeat (12) @(posedge pclk);
        rd_chk(`TMR_OFS_CTRL, 32'h45, "underflow flag");
        chk(irq_a === 1'b1, "underflow irq a");
    endtask : t_underflow

    task automatic t_freeze;
        logic [31:0] a, b, c;
        freeze <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`TMR_OFS_COUNT, a);
        rd(`TMR_OFS_COUNT, b);
        chk(a === b, "count held in freeze");
        freeze <= 1'b0;
        rd(`TMR_OFS_COUNT, c);
        chk(c !== b, "count resumes");
    endtask : t_freeze

    task automatic t_wave;
        logic [31:0] a, b;
        logic        s0, s1;
        s0 = 1'b0;
        s1 = 1'b0;
        wr(`TMR_OFS_CTRL, 32'h0);
        wr(`TMR_OFS_RELOAD_A, 32'h2);
        wr(`TMR_OFS_RELOAD_B, 32'h3);
        wr(`TMR_OFS_COUNT, 32'h1);
        wr(`TMR_OFS_CTRL, 32'h5B);
        repeat (30) begin
            @(posedge pclk);
            if (pin_out === 1'b1) s1 = 1'b1;
            if (pin_out === 1'b0) s0 = 1'b1;
        end
        chk(s0 && s1 && pin_oe === 1'b1, "pin a toggles");
        rd_chk(`TMR_OFS_CTRL, 32'hFB, "both reload flags");
        wr(`TMR_OFS_CTRL, 32'h5A);
        rd(`TMR_OFS_COUNT, a);
        rd(`TMR_OFS_COUNT, b);
        chk(a === b, "stopped count holds");
        wr(`TMR_OFS_CTRL, 32'h19);
        repeat (20) @(posedge pclk);
        wr(`TMR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        chk(pin_oe === 1'b0, "pin a released");
    endtask : t_wave

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, freeze, presetn} = 5'h0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_event();
        t_pin_b();
        t_capture();
        t_cap_modes();
        t_underflow();
        t_freeze();
        t_wave();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        stop_test();
    end
endmodule : tb_multimode_timer
